// ===== inc/eif_pkg.sv
// ----------------------------------------------------------------------
// external interrupt conditioning: shared constants and types
// ----------------------------------------------------------------------
package eif_pkg;

  // ----------------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------------
  localparam int unsigned NPIN    = 6;        // external interrupt pins
  localparam int unsigned ADDR_W  = 8;        // byte address width on the bus
  localparam int unsigned DATA_W  = 32;       // bus data width
  localparam int unsigned IDX_W   = 6;        // word index width
  localparam int unsigned DIV_W   = 4;        // gear clock prescaler width
  localparam int unsigned LSDIV_W = 2;        // low-speed divider width

  // ----------------------------------------------------------------------
  // register word indices (byte address = index * 4)
  // ----------------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_GATE   = 6'h00; // block clock gate register
  localparam logic [IDX_W-1:0] IDX_CTRL1  = 6'h01; // control, pin one
  localparam logic [IDX_W-1:0] IDX_CTRL4  = 6'h04; // control, pin four
  localparam logic [IDX_W-1:0] IDX_STATUS = 6'h05; // filtered pin levels

  // ----------------------------------------------------------------------
  // field layout of a control register (low byte of the word)
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [2:0] zero;      // reads as zero
    logic       lvl;       // captured_level_bit, read only
    logic [1:0] cond;      // request condition
    logic [1:0] smpl;      // sampling interval
  } eif_ctrl_s;

  localparam eif_ctrl_s CTRL_RST = '{zero: 3'h0, lvl: 1'b0, cond: 2'h0, smpl: 2'h0};
  localparam logic      GATE_RST = 1'b0;      // irq_clock_gate_bit after reset

  // ----------------------------------------------------------------------
  // condition and sampling codes
  // ----------------------------------------------------------------------
  localparam logic [1:0] COND_RISE = 2'h0;
  localparam logic [1:0] COND_FALL = 2'h1;
  localparam logic [1:0] COND_BOTH = 2'h2;
  localparam logic [1:0] COND_HIGH = 2'h3;    // pin four only, else reserved
  localparam logic [1:0] SMPL_D1   = 2'h0;
  localparam logic [1:0] SMPL_D4   = 2'h1;
  localparam logic [1:0] SMPL_D8   = 2'h2;
  localparam logic [DIV_W-1:0]   DIV4_END  = 4'h3;  // last count of /4
  localparam logic [DIV_W-1:0]   DIV8_END  = 4'h7;  // last count of /8
  localparam logic [DIV_W-1:0]   DIV16_END = 4'hf;  // last count of /16
  localparam logic [LSDIV_W-1:0] LSDIV_END = 2'h3;  // last count of fs/4

  // ----------------------------------------------------------------------
  // operating mode input codes
  // ----------------------------------------------------------------------
  localparam logic [1:0] MODE_HS   = 2'h0;    // high-speed run or halt
  localparam logic [1:0] MODE_LS   = 2'h1;    // low-speed run or light sleep
  localparam logic [1:0] MODE_DEEP = 2'h2;    // deep halt, deep sleep, stop

  // ----------------------------------------------------------------------
  // bus answers
  // ----------------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ===== rtl/eif_noise_filter.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// one-pin digital noise canceller
// ----------------------------------------------------------------------
module eif_noise_filter #(
  parameter bit FIXED = 1'b0                  // fixed-filter pin
) (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic pin,                      // masked pin level
  input  wire logic run,                      // gate on and not deep mode
  input  wire logic hs_mode,                  // high-speed modes
  input  wire logic smpl_tick,                // selected interval tick
  input  wire logic ls_tick,                  // low-frequency clock / 4
  output logic      level                     // filtered level
);

  logic [2:0] hist_r;                         // last three samples
  logic [2:0] hist_nxt;
  logic       level_r;
  wire        tick_w   = hs_mode ? (FIXED ? 1'b1 : smpl_tick) : ls_tick;
  wire        take_w   = run & tick_w;
  // fixed pins and low-speed modes need two agreeing samples, else three
  wire        need2_w  = FIXED | ~hs_mode;
  wire        agree2_w = (hist_nxt[1] == hist_nxt[0]);
  wire        agree3_w = agree2_w & (hist_nxt[2] == hist_nxt[1]);
  wire        accept_w = take_w & (need2_w ? agree2_w : agree3_w);

  assign hist_nxt = {hist_r[1:0], pin};
  assign level    = level_r;

  // sample history; a halted filter keeps its history
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hist_r  <= 3'h0;
      level_r <= 1'b0;
    end else begin
      if (take_w) begin
        hist_r <= hist_nxt;
      end
      if (accept_w) begin
        level_r <= hist_nxt[0];
      end
    end
  end

endmodule
`default_nettype wire

// ===== rtl/eif_req_detect.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// request condition decoder for one pin
// ----------------------------------------------------------------------
module eif_req_detect #(
  parameter bit HIGH_OK = 1'b0                // code 11 means high level
) (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       run,
  input  wire logic       level,              // filtered level
  input  wire logic [1:0] cond,
  output logic            req                 // request this cycle
);

  logic prev_r;                               // filtered level one cycle ago
  wire  rise_w = level & ~prev_r;
  wire  fall_w = ~level & prev_r;

  // compare with previous filtered level
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= level;
    end
  end

  // reserved code raises nothing on pins one to three
  assign req = run & ((cond == eif_pkg::COND_RISE) ? rise_w :
                      (cond == eif_pkg::COND_FALL) ? fall_w :
                      (cond == eif_pkg::COND_BOTH) ? (rise_w | fall_w) :
                      (HIGH_OK & level));

endmodule
`default_nettype wire

// ===== rtl/eif_top.sv
`timescale 1ns/1ps
`default_nettype none
module eif_top (
  input  wire logic                       sys_clk,
  input  wire logic                       arst_n,
  // axi4-lite slave
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [eif_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  input  wire logic [eif_pkg::DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  output logic [1:0]                      s_axi_bresp,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  input  wire logic [eif_pkg::ADDR_W-1:0] s_axi_araddr,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  output logic [eif_pkg::DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  // system side
  input  wire logic [1:0]                 op_mode,
  input  wire logic                       fs_tick,
  input  wire logic                       ext_irq_pin_zero,
  input  wire logic                       ext_irq_pin_one,
  input  wire logic                       ext_irq_pin_two,
  input  wire logic                       ext_irq_pin_three,
  input  wire logic                       ext_irq_pin_four,
  input  wire logic                       ext_irq_pin_five,
  input  wire logic [eif_pkg::NPIN-1:0]   pin_out_mode,
  output logic [eif_pkg::NPIN-1:0]        irq_req
);

  // ----------------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------------
  logic [1:0] rst_sync_r;                     // two-stage release
  wire        rst_n = rst_sync_r[1];          // design reset

  // async assert, release after two edges
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end

  // ----------------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------------
  logic                     gate_r;           // irq_clock_gate_bit
  eif_pkg::eif_ctrl_s       ctrl_r [1:4];     // ext_irq_control_reg for pins one to four
  logic [eif_pkg::NPIN-1:0] level_w;          // filtered levels
  logic [eif_pkg::NPIN-1:0] req_w;            // raw requests
  logic [eif_pkg::NPIN-1:0] req_r;            // registered requests

  // ----------------------------------------------------------------------
  // mode and sampling timebase
  // ----------------------------------------------------------------------
  wire hs_w   = (op_mode == eif_pkg::MODE_HS);
  wire ls_w   = (op_mode == eif_pkg::MODE_LS);
  // a stopped block clock or deep mode freezes the prescalers, filters and requests
  wire run_w  = gate_r & (hs_w | ls_w);

  logic [eif_pkg::DIV_W-1:0]   div_r;         // gear clock prescaler
  logic [eif_pkg::LSDIV_W-1:0] lsdiv_r;       // counts low-frequency periods

  wire d4_w   = (div_r[1:0] == eif_pkg::DIV4_END[1:0]);
  wire d8_w   = (div_r[2:0] == eif_pkg::DIV8_END[2:0]);
  wire d16_w  = (div_r == eif_pkg::DIV16_END);
  wire ls_tick_w = fs_tick & (lsdiv_r == eif_pkg::LSDIV_END);

  // prescalers run only while the block clock would run
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_r   <= '0;
      lsdiv_r <= '0;
    end else if (run_w) begin
      div_r <= div_r + 4'h1;
      if (fs_tick) begin
        lsdiv_r <= lsdiv_r + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // pin masking: a pin in output mode reads low inside
  // ----------------------------------------------------------------------
  wire [eif_pkg::NPIN-1:0] pin_raw_w = {ext_irq_pin_five, ext_irq_pin_four,
                                        ext_irq_pin_three, ext_irq_pin_two,
                                        ext_irq_pin_one, ext_irq_pin_zero};
  wire [eif_pkg::NPIN-1:0] pin_w     = pin_raw_w & ~pin_out_mode;

  // ----------------------------------------------------------------------
  // bus slave: write channel holders
  // ----------------------------------------------------------------------
  logic                       awready_r;      // address slot free
  logic                       wready_r;       // data slot free
  logic                       aw_hold_r;      // address taken, not used
  logic                       w_hold_r;       // data taken, not used
  logic [eif_pkg::IDX_W-1:0]  aw_idx_r;       // held word index
  logic [7:0]                 wdata_r;        // held low byte
  logic                       wstrb0_r;       // held lane-0 strobe
  logic                       bvalid_r;
  logic [1:0]                 bresp_r;

  wire aw_hs_w = s_axi_awvalid & awready_r;
  wire w_hs_w  = s_axi_wvalid & wready_r;
  wire b_hs_w  = bvalid_r & s_axi_bready;
  // both halves present and no answer pending
  wire wr_go_w = aw_hold_r & w_hold_r & ~bvalid_r;
  wire wr_en_w = wr_go_w & wstrb0_r;

  // write decode
  wire wr_gate_w   = wr_en_w & (aw_idx_r == eif_pkg::IDX_GATE);
  wire wr_ok_w     = (aw_idx_r <= eif_pkg::IDX_STATUS);

  // write handshakes: each channel taken once, freed after response
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      aw_idx_r  <= '0;
      wdata_r   <= '0;
      wstrb0_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= eif_pkg::RESP_OKAY;
    end else begin
      if (aw_hs_w) begin
        awready_r <= 1'b0;
        aw_hold_r <= 1'b1;
        aw_idx_r  <= s_axi_awaddr[eif_pkg::ADDR_W-1:2];
      end
      if (w_hs_w) begin
        wready_r <= 1'b0;
        w_hold_r <= 1'b1;
        wdata_r  <= s_axi_wdata[7:0];
        wstrb0_r <= s_axi_wstrb[0];
      end
      if (wr_go_w) begin
        aw_hold_r <= 1'b0;
        w_hold_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= wr_ok_w ? eif_pkg::RESP_OKAY : eif_pkg::RESP_SLVERR;
      end
      if (b_hs_w) begin
        bvalid_r  <= 1'b0;
        awready_r <= 1'b1;
        wready_r  <= 1'b1;
      end
    end
  end

  // gate bit, cleared by reset so the block starts unclocked
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      gate_r <= eif_pkg::GATE_RST;
    end else if (wr_gate_w) begin
      gate_r <= wdata_r[0];
    end
  end

  // ----------------------------------------------------------------------
  // per-pin filter and condition; control register on pins one to four only
  // ----------------------------------------------------------------------
  logic [1:0] cond_w [0:5];                   // effective condition
  logic [1:0] smpl_w [0:5];                   // effective interval code

  genvar g;
  generate
    for (g = 0; g < eif_pkg::NPIN; g++) begin : g_pin
      localparam bit FIXED = (g == 0) || (g == eif_pkg::NPIN - 1);
      wire tick_w;

      if (FIXED) begin : g_fixed
        // fixed pins: falling edge, gear-clock filter
        assign cond_w[g] = eif_pkg::COND_FALL;
        assign smpl_w[g] = eif_pkg::SMPL_D1;
      end else begin : g_cfg
        wire wr_w = wr_en_w & (aw_idx_r == 6'(g));
        assign cond_w[g] = ctrl_r[g].cond;
        assign smpl_w[g] = ctrl_r[g].smpl;

        // writable fields and the captured level; hardware never loses a capture
        always_ff @(posedge sys_clk or negedge rst_n) begin
          if (!rst_n) begin
            ctrl_r[g] <= eif_pkg::CTRL_RST;
          end else begin
            if (wr_w) begin
              ctrl_r[g].cond <= wdata_r[3:2];
              ctrl_r[g].smpl <= wdata_r[1:0];
            end
            if (req_w[g]) begin
              ctrl_r[g].lvl <= level_w[g];
            end
          end
        end
      end

      // interval select from the shared prescaler
      assign tick_w = (smpl_w[g] == eif_pkg::SMPL_D1) ? 1'b1 :
                      (smpl_w[g] == eif_pkg::SMPL_D4) ? d4_w :
                      (smpl_w[g] == eif_pkg::SMPL_D8) ? d8_w : d16_w;

      eif_noise_filter #(
        .FIXED     (FIXED)
      ) u_filt (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .pin       (pin_w[g]),
        .run       (run_w),
        .hs_mode   (hs_w),
        .smpl_tick (tick_w),
        .ls_tick   (ls_tick_w),
        .level     (level_w[g])
      );

      eif_req_detect #(
        .HIGH_OK   (g == 4)
      ) u_det (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .run       (run_w),
        .level     (level_w[g]),
        .cond      (cond_w[g]),
        .req       (req_w[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // request outputs to the interrupt latch
  // ----------------------------------------------------------------------
  // registered so the latch sees a clean one-cycle pulse per edge
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_r <= '0;
    end else begin
      req_r <= req_w;
    end
  end

  assign irq_req = req_r;

  // ----------------------------------------------------------------------
  // bus slave: read channel
  // ----------------------------------------------------------------------
  logic                      arready_r;
  logic                      rvalid_r;
  logic [eif_pkg::DATA_W-1:0] rdata_r;
  logic [1:0]                rresp_r;

  wire [eif_pkg::IDX_W-1:0] rd_idx_w = s_axi_araddr[eif_pkg::ADDR_W-1:2];
  wire ar_hs_w = s_axi_arvalid & arready_r;
  wire r_hs_w  = rvalid_r & s_axi_rready;

  // control words read with bits 7:5 as zero
  wire [7:0] rd_c1_w = {3'h0, ctrl_r[1].lvl, ctrl_r[1].cond, ctrl_r[1].smpl};
  wire [7:0] rd_c2_w = {3'h0, ctrl_r[2].lvl, ctrl_r[2].cond, ctrl_r[2].smpl};
  wire [7:0] rd_c3_w = {3'h0, ctrl_r[3].lvl, ctrl_r[3].cond, ctrl_r[3].smpl};
  wire [7:0] rd_c4_w = {3'h0, ctrl_r[4].lvl, ctrl_r[4].cond, ctrl_r[4].smpl};
  wire       rd_ok_w = (rd_idx_w <= eif_pkg::IDX_STATUS);
  // read mux; unmapped words read zero
  wire [7:0] rd_byte_w =
    (rd_idx_w == eif_pkg::IDX_GATE)   ? {7'h00, gate_r} :
    (rd_idx_w == eif_pkg::IDX_CTRL1)  ? rd_c1_w :
    (rd_idx_w == 6'h02)               ? rd_c2_w :
    (rd_idx_w == 6'h03)               ? rd_c3_w :
    (rd_idx_w == eif_pkg::IDX_CTRL4)  ? rd_c4_w :
    (rd_idx_w == eif_pkg::IDX_STATUS) ? {2'h0, level_w} : 8'h00;

  // one read at a time; address slot reopens after the data is taken
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= '0;
      rresp_r   <= eif_pkg::RESP_OKAY;
    end else begin
      if (ar_hs_w) begin
        arready_r <= 1'b0;
        rvalid_r  <= 1'b1;
        rdata_r   <= {24'h000000, rd_byte_w};
        rresp_r   <= rd_ok_w ? eif_pkg::RESP_OKAY : eif_pkg::RESP_SLVERR;
      end
      if (r_hs_w) begin
        rvalid_r  <= 1'b0;
        arready_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // bus outputs straight from flops
  // ----------------------------------------------------------------------
  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  // note: software must disable each interrupt before changing the gate,
  // controls or mode, and wait the settling time afterwards

endmodule
`default_nettype wire

// ===== testbench/eif_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// bus handshake and request checks at the top ports
// ----
module eif_chk (
  input wire logic        sys_clk,
  input wire logic        arst_n,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic [1:0]  op_mode,
  input wire logic        ext_irq_pin_zero,
  input wire logic [5:0]  pin_out_mode,
  input wire logic [5:0]  irq_req
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // both halves of a write taken at one edge
  sequence s_w_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  AST_W_BUSY: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write ready while answering");
  AST_R_BUSY: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("arready early");
  AST_R_FAST: assert property (s_ar_take |=> s_axi_rvalid) else $error("read answer late");
  AST_B_ANS: assert property (s_w_take |-> ##[1:2] s_axi_bvalid) else $error("no write answer");
  AST_R_ERR: assert property (s_axi_rvalid && s_axi_rresp != eif_pkg::RESP_OKAY
    |-> s_axi_rresp == eif_pkg::RESP_SLVERR && s_axi_rdata == 32'h0) else $error("bad error read");
  AST_DEEP: assert property (op_mode[1] [*3] |-> irq_req == 6'h00)
    else $error("request in deep mode");
  AST_PULSE: assert property ((irq_req & 6'h2f) != 6'h00
    |=> (irq_req & $past(irq_req) & 6'h2f) == 6'h00) else $error("request not one cycle");
  AST_FALL0: assert property (irq_req[0]
    |-> !$past(ext_irq_pin_zero, 2) || $past(pin_out_mode[0], 2)) else $error("pin zero request on high");
endmodule
bind eif_top eif_chk u_chk (.sys_clk, .arst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .op_mode, .ext_irq_pin_zero,
  .pin_out_mode, .irq_req);
`default_nettype wire

// ===== testbench/eif_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// far side: slow clock tick and the request latch counters
// ----
module eif_pin_model #(
  parameter int FS_DIV = 2              // system clocks per slow period
) (
  input wire logic        sys_clk,
  input wire logic        clr,
  input wire logic [5:0]  irq_req,
  output logic            fs_tick,
  output logic [5:0][7:0] cnt
);
  logic [7:0] div_r = 8'h00;            // slow clock runs free, also in deep modes
  assign fs_tick = (div_r == 8'h00);
  // latch counts every cycle a request stands
  always @(posedge sys_clk) begin
    div_r <= (div_r == 8'(FS_DIV - 1)) ? 8'h00 : div_r + 8'h01;
    for (int i = 0; i < 6; i++) cnt[i] <= clr ? 8'h00 : cnt[i] + 8'(irq_req[i]);
  end
endmodule
`default_nettype wire

// ===== testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ----
  // stimulus, bus tasks and request counting
  // ----
  localparam logic [1:0] OK = eif_pkg::RESP_OKAY;
  localparam logic [1:0] ER = eif_pkg::RESP_SLVERR;
  logic        sys_clk, arst_n, clr, fs_tick;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, op_mode;
  logic [5:0]  pins, pin_out_mode, irq_req;
  logic [5:0][7:0] cnt;
  int          fails, total_checks, cyc, n;
  eif_top dut (.sys_clk, .arst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .op_mode, .fs_tick,
    .ext_irq_pin_zero(pins[0]), .ext_irq_pin_one(pins[1]), .ext_irq_pin_two(pins[2]),
    .ext_irq_pin_three(pins[3]), .ext_irq_pin_four(pins[4]), .ext_irq_pin_five(pins[5]),
    .pin_out_mode, .irq_req);
  eif_pin_model #(.FS_DIV(2)) u_far (.sys_clk, .clr, .irq_req, .fs_tick, .cnt);
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // hang guard, far above the expected run length
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc > 40000) begin
      fails++;
      complete_run();
    end
  end
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // address and data offered together, held until each ready
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge sys_clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(48'(s_axi_bresp), 48'(r));
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    @(posedge sys_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk({s_axi_rresp, s_axi_rdata}, {14'h0, r, e});
  endtask
  // pin held at v for w cycles, then back, then time to settle
  task automatic pulse(input int i, input logic v, input int w);
    @(posedge sys_clk);
    pins[i] <= v;
    repeat (w) @(posedge sys_clk);
    pins[i] <= ~v;
    repeat (100) @(posedge sys_clk);
  endtask
  task automatic zap();
    clr <= 1'b1;
    @(posedge sys_clk);
    clr <= 1'b0;
    @(posedge sys_clk);
  endtask
  // only pin i may have requested, exactly e cycles
  task automatic cc(input int i, input int e);
    chk(cnt, 48'(e) << (8 * i));
    zap();
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, pins, pin_out_mode, op_mode, arst_n} = 63'h0;
    s_axi_wstrb = 4'hf;
    clr = 1'b1;
    repeat (8) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rd_chk(8'h00, 32'h0, OK);
    rd_chk(8'h04, 32'h0, OK);
    wr(8'h40, 32'h1, ER);
    rd_chk(8'h40, 32'h0, ER);
    wr(8'h00, 32'h1, OK);
    rd_chk(8'h00, 32'h1, OK);
    wr(8'h04, 32'hff, OK);
    rd_chk(8'h04, 32'h0f, OK);
    zap();
    pulse(1, 1'b1, 80);
    cc(1, 0);
    $display("test registers done");
    pins <= 6'h21;
    repeat (20) @(posedge sys_clk);
    cc(0, 0);
    for (int p = 0; p < 6; p += 5) begin
      pulse(p, 1'b0, 2);
      cc(p, 1);
    end
    for (int p = 1; p < 4; p++) begin
      for (int c = 0; c < 3; c++) begin
        wr(8'(4 * p), 32'(c << 2), OK);
        pulse(p, 1'b1, 10);
        cc(p, (c == 2) ? 2 : 1);
        rd_chk(8'(4 * p), ((c == 0) ? 32'h10 : 32'h0) | 32'(c << 2), OK);
      end
    end
    for (int s = 0; s < 4; s++) begin
      n = (s == 0) ? 1 : (4 << (s - 1));
      wr(8'h08, 32'(s), OK);
      pulse(2, 1'b1, 2 * n - 1);
      cc(2, 0);
      pulse(2, 1'b1, 4 * n + 2);
      cc(2, 1);
    end
    wr(8'h10, 32'h0c, OK);
    pulse(4, 1'b1, 30);
    chk(48'(cnt[4] > 8'd20), 48'h1);
    zap();
    rd_chk(8'h10, 32'h1c, OK);
    $display("test conditions done");
    pin_out_mode <= 6'h01;
    repeat (10) @(posedge sys_clk);
    pin_out_mode <= 6'h00;
    repeat (60) @(posedge sys_clk);
    cc(0, 1);
    op_mode <= eif_pkg::MODE_LS;
    repeat (60) @(posedge sys_clk);
    zap();
    pulse(0, 1'b0, 7);
    cc(0, 0);
    pulse(5, 1'b0, 18);
    cc(5, 1);
    op_mode <= eif_pkg::MODE_DEEP;
    repeat (60) @(posedge sys_clk);
    zap();
    pulse(0, 1'b0, 20);
    cc(0, 0);
    op_mode <= eif_pkg::MODE_HS;
    repeat (60) @(posedge sys_clk);
    zap();
    wr(8'h00, 32'h0, OK);
    pulse(0, 1'b0, 20);
    cc(0, 0);
    $display("test modes done");
    complete_run();
  end
endmodule
`default_nettype wire
